/* src/fspg_pkg.sv */
// Package for the flash self programming guard: register map, fields, states, carriers
package fspg_pkg;

  // Peripheral register byte addresses
  localparam logic [15:0] FSPG_ADDR_PROTECT_KEY = 16'hFFA0;
  localparam logic [15:0] FSPG_ADDR_ERROR_STATUS = 16'hFFA1;
  localparam logic [15:0] FSPG_ADDR_MODE_CONTROL = 16'hFFA2;
  localparam logic [15:0] FSPG_ADDR_COMMAND = 16'hFFA3;
  localparam logic [15:0] FSPG_ADDR_PTR_HIGH = 16'hFFA4;
  localparam logic [15:0] FSPG_ADDR_PTR_LOW = 16'hFFA5;

  // Unlock key value
  localparam logic [7:0] FSPG_KEY_VALUE = 8'hA5;

  // Status field positions and reset value
  localparam int FSPG_ST_PROT_SEQ_BIT = 0;
  localparam int FSPG_ST_VERIFY_BIT = 1;
  localparam int FSPG_ST_WE_PROT_BIT = 2;
  localparam logic [2:0] FSPG_STATUS_RESET = 3'h0;

  // Mode control field positions and reset value
  localparam int FSPG_MODE_SELECT_BIT = 0;
  localparam int FSPG_MODE_PROT_LSB = 2;
  localparam logic FSPG_SELECT_RESET = 1'b0;

  // Command codes and reset value
  localparam logic [2:0] FSPG_CMD_RESET = 3'h0;
  localparam logic [2:0] FSPG_CMD_VERIFY = 3'h1;
  localparam logic [2:0] FSPG_CMD_BLOCK_ERASE = 3'h3;
  localparam logic [2:0] FSPG_CMD_BLANK_CHECK = 3'h4;
  localparam logic [2:0] FSPG_CMD_BYTE_WRITE = 3'h5;

  // Value returned for unmapped or write-only reads
  localparam logic [7:0] FSPG_READ_ZERO = 8'h00;

  // Unlock sequence states, Gray coded along the normal path
  typedef enum logic [1:0] {
    FSPG_SEQ_IDLE = 2'b00,
    FSPG_SEQ_KEYED = 2'b01,
    FSPG_SEQ_FIRST = 2'b11,
    FSPG_SEQ_INVERTED = 2'b10
  } fspg_seq_t;

  // One peripheral access from the CPU core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fspg_req_t;

  // Result events from the flash sequencer
  typedef struct packed {
    logic exec_start;
    logic blk_protected;
    logic verify_fail;
    logic overwrite_fail;
    logic ptr_step;
  } fspg_evt_t;

  // Decoded command presented to the flash sequencer
  typedef struct packed {
    logic self_prog;
    logic legal;
    logic [2:0] code;
  } fspg_cmd_t;

  // Legal command code check
  function automatic logic fspg_cmd_legal(input logic [2:0] code);
    fspg_cmd_legal = (code == FSPG_CMD_VERIFY) || (code == FSPG_CMD_BLOCK_ERASE) ||
                     (code == FSPG_CMD_BLANK_CHECK) || (code == FSPG_CMD_BYTE_WRITE);
  endfunction

endpackage

/* src/fspg_top.sv */
// Flash self programming guard: unlock sequence, error status, command and pointer registers
// Functional notes
// RL1: Mode control is written only after key, value, inverse, value store order.
// RL2: Only the fourth store updates the self programming select bit.
// RL3: Software writes the key again before every mode control change.
// RL4: A broken sequence leaves mode control unchanged and flags an error.
// RL5: Protection error sets status bit 0.
// RL6: Key write in the middle of a sequence flags a protection error.
// RL7: A store to another register inside the sequence flags an error.
// RL8: Second mode write not the inverse of the first flags an error.
// RL9: Third mode write differing from the first flags an error.
// RL10: Writing 0 to a status flag clears it.
// RL11: Status resets to zero; bits 7 to 3 read zero.
// RL12: Verify error bit 1 sets on erase or write verification failure.
// RL13: Verify error may also set on a protect error.
// RL14: Command on a protected block sets status bit 2.
// RL15: Byte write turning a 0 bit into 1 sets status bit 2.
// RL16: Command codes 001, 011, 100, 101 are legal; others prohibited.
// RL17: Prohibited code on mode entry leaves the mode, runs nothing, sets no flag.
// RL18: Internal verify checks start to end range and flags failures.
// RL19: Pointer pair counts up until it matches the compare pair.
// RL20: Pointer registers are undefined after reset.
// RL21: Software clears bits 7 to 4 of pointer high and its compare.
// RL22: Software clears all status flags before each operation.
// RL23: Software masks interrupts during the unlock sequence.
// RL24: Protect key is an eight-bit write-only register, undefined after reset.
// RL25: Select bit 0 means normal at 0, self programming at 1; resets to 0.
// RL26: Compare high equals pointer high; compare low is the last address.
// RL27: Writing 1 to a status flag leaves it unchanged.
`timescale 1ns/1ps
`default_nettype none

module fspg_top
  import fspg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Peripheral access from the CPU core
  input wire fspg_req_t per_req,
  output logic [7:0] per_rdata,
  // Sequencer side
  input wire fspg_evt_t seq_evt,
  input wire logic [4:0] prot_setting,
  input wire logic [7:0] cmp_high,
  input wire logic [7:0] cmp_low,
  output fspg_cmd_t cmd_out,
  output logic [7:0] ptr_high,
  output logic [7:0] ptr_low
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_key;
  logic wr_status;
  logic wr_mode;
  logic wr_cmd;
  logic wr_ptr_high;
  logic wr_ptr_low;
  logic any_store;

  assign any_store = per_req.wr;
  assign wr_key = per_req.wr && (per_req.addr == FSPG_ADDR_PROTECT_KEY);
  assign wr_status = per_req.wr && (per_req.addr == FSPG_ADDR_ERROR_STATUS);
  assign wr_mode = per_req.wr && (per_req.addr == FSPG_ADDR_MODE_CONTROL);
  assign wr_cmd = per_req.wr && (per_req.addr == FSPG_ADDR_COMMAND);
  assign wr_ptr_high = per_req.wr && (per_req.addr == FSPG_ADDR_PTR_HIGH);
  assign wr_ptr_low = per_req.wr && (per_req.addr == FSPG_ADDR_PTR_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock sequence

  fspg_seq_t seq_ff;
  fspg_seq_t nxt_seq;
  logic [7:0] first_val_ff;
  logic [7:0] key_ff;
  logic seq_err;
  logic mode_commit;

  always_comb begin
    nxt_seq = seq_ff;
    seq_err = 1'b0;
    mode_commit = 1'b0;
    if (any_store) begin
      unique case (seq_ff)
        FSPG_SEQ_IDLE: begin
          if (wr_key) begin
            // A wrong key simply fails to arm the sequence
            if (per_req.wdata == FSPG_KEY_VALUE) begin
              nxt_seq = FSPG_SEQ_KEYED; // RL1
            end
          end else if (wr_mode) begin
            seq_err = 1'b1; // RL4
          end
        end
        FSPG_SEQ_KEYED: begin
          if (wr_mode) begin
            nxt_seq = FSPG_SEQ_FIRST; // RL1
          end else begin
            seq_err = 1'b1; // RL7
            nxt_seq = FSPG_SEQ_IDLE;
          end
        end
        FSPG_SEQ_FIRST: begin
          if (wr_mode && (per_req.wdata == ~first_val_ff)) begin
            nxt_seq = FSPG_SEQ_INVERTED; // RL1
          end else begin
            seq_err = 1'b1; // RL7 RL8
            nxt_seq = FSPG_SEQ_IDLE;
          end
        end
        FSPG_SEQ_INVERTED: begin
          if (wr_mode && (per_req.wdata == first_val_ff)) begin
            mode_commit = 1'b1; // RL2
          end else begin
            seq_err = 1'b1; // RL7 RL9
          end
          // Each unlock covers a single change only
          nxt_seq = FSPG_SEQ_IDLE; // RL3
        end
      endcase
      // Key written while a sequence is open counts as an illegal store
      if (wr_key && (seq_ff != FSPG_SEQ_IDLE)) begin
        seq_err = 1'b1; // RL6
        nxt_seq = FSPG_SEQ_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seq_ff <= FSPG_SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_mode && (seq_ff == FSPG_SEQ_KEYED)) begin
      first_val_ff <= per_req.wdata;
    end
  end

  // Key has no reset; it only exists to be written
  always_ff @(posedge clk) begin
    if (wr_key) begin
      key_ff <= per_req.wdata; // RL24
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode select and command

  logic select_ff;
  logic [2:0] cmd_ff;
  logic cmd_ok;

  assign cmd_ok = fspg_cmd_legal(cmd_ff); // RL16

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      select_ff <= FSPG_SELECT_RESET; // RL25
    end else if (mode_commit) begin
      select_ff <= per_req.wdata[FSPG_MODE_SELECT_BIT]; // RL2
    end else if (select_ff && !cmd_ok) begin
      // Entry with a prohibited code is dropped without any flag
      select_ff <= 1'b0; // RL17
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_ff <= FSPG_CMD_RESET;
    end else if (wr_cmd) begin
      cmd_ff <= per_req.wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_out <= '0;
    end else begin
      cmd_out.self_prog <= select_ff && cmd_ok; // RL17
      cmd_out.legal <= cmd_ok;
      cmd_out.code <= cmd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error status

  logic [2:0] status_ff;
  logic [2:0] status_set;
  logic [2:0] status_keep;
  logic run_ok;

  // Sequencer flag events only count while a legal command runs in self programming; ptr_step is not gated
  assign run_ok = select_ff && cmd_ok; // RL17

  always_comb begin
    status_set = 3'h0;
    status_set[FSPG_ST_PROT_SEQ_BIT] = seq_err; // RL5
    status_set[FSPG_ST_VERIFY_BIT] = run_ok && seq_evt.verify_fail; // RL12 RL13 RL18
    status_set[FSPG_ST_WE_PROT_BIT] = run_ok &&
      ((seq_evt.exec_start && seq_evt.blk_protected) || // RL14
       (seq_evt.overwrite_fail && (cmd_ff == FSPG_CMD_BYTE_WRITE))); // RL15
    // Writing 1 keeps a flag, writing 0 clears it
    status_keep = wr_status ? per_req.wdata[2:0] : 3'h7; // RL10 RL27
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_ff <= FSPG_STATUS_RESET; // RL11
    end else begin
      // Set beats clear so an event in the clearing cycle is kept
      status_ff <= (status_ff & status_keep) | status_set; // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address pointer counter

  logic [7:0] ptr_high_ff;
  logic [7:0] ptr_low_ff;
  logic ptr_match;

  assign ptr_match = (ptr_high_ff == cmp_high) && (ptr_low_ff == cmp_low);

  // No reset: software loads both bytes before every command
  always_ff @(posedge clk) begin
    if (wr_ptr_high || wr_ptr_low) begin
      if (wr_ptr_high) begin
        ptr_high_ff <= per_req.wdata; // RL20
      end
      if (wr_ptr_low) begin
        ptr_low_ff <= per_req.wdata; // RL20
      end
    end else if (seq_evt.ptr_step && !ptr_match) begin
      {ptr_high_ff, ptr_low_ff} <= 16'({ptr_high_ff, ptr_low_ff} + 16'h0001); // RL19
    end
  end

  assign ptr_high = ptr_high_ff;
  assign ptr_low = ptr_low_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  always_comb begin
    rd_mux = FSPG_READ_ZERO;
    unique case (per_req.addr)
      FSPG_ADDR_ERROR_STATUS: rd_mux = {5'h00, status_ff}; // RL11
      FSPG_ADDR_MODE_CONTROL: rd_mux = {1'b0, prot_setting, 1'b0, select_ff};
      FSPG_ADDR_COMMAND: rd_mux = {5'h00, cmd_ff};
      FSPG_ADDR_PTR_HIGH: rd_mux = ptr_high_ff;
      FSPG_ADDR_PTR_LOW: rd_mux = ptr_low_ff;
      default: rd_mux = FSPG_READ_ZERO; // RL24
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_ff <= FSPG_READ_ZERO;
    end else if (per_req.rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign per_rdata = rdata_ff;

endmodule

`default_nettype wire

/* dv/fspg_cpu_model.sv */
// CPU core model issuing peripheral stores and reads
`timescale 1ns/1ps
`default_nettype none

module fspg_cpu_model
  import fspg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Peripheral access
  output var fspg_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;

  // One whole store per call, so nothing else lands between unlock steps
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    // Released lines flip so stale values cannot pass for fresh ones
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  task automatic load(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    req.addr = ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

`default_nettype wire

/* dv/fspg_chk.sv */
// Checker for the flash self programming guard ports
`timescale 1ns/1ps
`default_nettype none

module fspg_chk
  import fspg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire fspg_req_t per_req,
  input wire logic [7:0] per_rdata,
  input wire fspg_evt_t seq_evt,
  input wire logic [4:0] prot_setting,
  input wire logic [7:0] cmp_high,
  input wire logic [7:0] cmp_low,
  input wire fspg_cmd_t cmd_out,
  input wire logic [7:0] ptr_high,
  input wire logic [7:0] ptr_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  chk_status_zero: assert property (
    per_req.rd && per_req.addr == FSPG_ADDR_ERROR_STATUS |-> ##2 per_rdata[7:3] == 5'h00)
    else $error("status upper bits not zero");
  chk_key_unread: assert property (
    per_req.rd && per_req.addr == FSPG_ADDR_PROTECT_KEY |-> ##2 per_rdata == 8'h00)
    else $error("key register readable");
  chk_legal_decode: assert property (
    cmd_out.legal == (cmd_out.code inside {3'h1, 3'h3, 3'h4, 3'h5}))
    else $error("command legality wrong");
  chk_illegal_exit: assert property (
    cmd_out.self_prog |-> cmd_out.legal)
    else $error("self programming with illegal code");
  chk_entry_cause: assert property (
    $rose(cmd_out.self_prog) |-> $past(per_req.wr, 2))
    else $error("self programming entered without a store");
  chk_ptr_load: assert property (
    per_req.wr && per_req.addr == FSPG_ADDR_PTR_HIGH |=> ptr_high == $past(per_req.wdata))
    else $error("pointer high not loaded");
  chk_ptr_count: assert property (
    seq_evt.ptr_step && !per_req.wr && {ptr_high, ptr_low} != {cmp_high, cmp_low}
    |=> {ptr_high, ptr_low} == $past({ptr_high, ptr_low}) + 16'h0001)
    else $error("pointer did not advance");
  chk_ptr_stop: assert property (
    seq_evt.ptr_step && !per_req.wr && {ptr_high, ptr_low} == {cmp_high, cmp_low}
    |=> $stable({ptr_high, ptr_low}))
    else $error("pointer ran past compare");
endmodule

bind fspg_top fspg_chk i_chk (.clk(clk), .rst_b(rst_b), .per_req(per_req),
  .per_rdata(per_rdata), .seq_evt(seq_evt), .prot_setting(prot_setting),
  .cmp_high(cmp_high), .cmp_low(cmp_low), .cmd_out(cmd_out),
  .ptr_high(ptr_high), .ptr_low(ptr_low));

`default_nettype wire

/* dv/fspg_top_tb.sv */
// Self-checking testbench for the flash self programming guard
`timescale 1ns/1ps
`default_nettype none

module fspg_top_tb;
  import fspg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  fspg_req_t per_req;
  fspg_evt_t seq_evt = '0;
  logic [4:0] prot_setting = 5'h1B;
  logic [7:0] cmp_high = 8'h03;
  logic [7:0] cmp_low = 8'hFF;
  logic [7:0] per_rdata;
  logic [7:0] ptr_high;
  logic [7:0] ptr_low;
  fspg_cmd_t cmd_out;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  fspg_cpu_model i_cpu (.clk(clk), .req(per_req), .rdata(per_rdata));
  fspg_top i_dut (.clk(clk), .rst_b(rst_b), .per_req(per_req), .per_rdata(per_rdata),
    .seq_evt(seq_evt), .prot_setting(prot_setting), .cmp_high(cmp_high),
    .cmp_low(cmp_low), .cmd_out(cmd_out), .ptr_high(ptr_high), .ptr_low(ptr_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      fails++;
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_cpu.load(a, d);
    chk(d, e);
  endtask

  task automatic ev(input fspg_evt_t e);
    @(negedge clk);
    seq_evt = e;
    @(negedge clk);
    seq_evt = '0;
  endtask

  task automatic unlock(input logic [7:0] v);
    i_cpu.store(FSPG_ADDR_PROTECT_KEY, FSPG_KEY_VALUE);
    i_cpu.store(FSPG_ADDR_MODE_CONTROL, v);
    i_cpu.store(FSPG_ADDR_MODE_CONTROL, ~v);
    i_cpu.store(FSPG_ADDR_MODE_CONTROL, v);
  endtask

  task automatic bad(input logic [15:0] a2, input logic [7:0] d2, input logic [15:0] a3,
                     input logic [7:0] d3);
    i_cpu.store(FSPG_ADDR_ERROR_STATUS, 8'h00);
    i_cpu.store(FSPG_ADDR_PROTECT_KEY, FSPG_KEY_VALUE);
    i_cpu.store(FSPG_ADDR_MODE_CONTROL, 8'h01);
    i_cpu.store(a2, d2);
    i_cpu.store(a3, d3);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h01);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6C);
  endtask

  task automatic t_broken();
    bad(FSPG_ADDR_MODE_CONTROL, 8'hFE, FSPG_ADDR_MODE_CONTROL, 8'h00);
    bad(FSPG_ADDR_MODE_CONTROL, 8'hFD, FSPG_ADDR_MODE_CONTROL, 8'h01);
    bad(FSPG_ADDR_COMMAND, 8'h01, FSPG_ADDR_MODE_CONTROL, 8'h01);
    bad(FSPG_ADDR_PROTECT_KEY, FSPG_KEY_VALUE, FSPG_ADDR_MODE_CONTROL, 8'hFE);
    i_cpu.store(FSPG_ADDR_ERROR_STATUS, 8'hFF);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h01);
    i_cpu.store(FSPG_ADDR_ERROR_STATUS, 8'h00);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h00);
  endtask

  task automatic t_unlock();
    rchk(FSPG_ADDR_PROTECT_KEY, 8'h00);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6C);
    i_cpu.store(FSPG_ADDR_COMMAND, 8'h01);
    unlock(8'h01);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6D);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h00);
    chk(8'(cmd_out.self_prog), 8'h01);
    unlock(8'h00);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6C);
  endtask

  task automatic t_events();
    i_cpu.store(FSPG_ADDR_COMMAND, 8'h05);
    unlock(8'h01);
    ev(5'b00100);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h02);
    ev(5'b00010);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h06);
    i_cpu.store(FSPG_ADDR_ERROR_STATUS, 8'h02);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h02);
    ev(5'b11000);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h06);
    unlock(8'h00);
    i_cpu.store(FSPG_ADDR_ERROR_STATUS, 8'h00);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      i_cpu.store(FSPG_ADDR_COMMAND, 8'(c));
      rchk(FSPG_ADDR_COMMAND, 8'(c));
      chk(8'(cmd_out.legal), 8'(c == 1 || c == 3 || c == 4 || c == 5));
      chk(8'(cmd_out.code), 8'(c));
    end
    i_cpu.store(FSPG_ADDR_COMMAND, 8'h02);
    unlock(8'h01);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6C);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h00);
    chk(8'(cmd_out.self_prog), 8'h00);
  endtask

  task automatic t_pointer();
    i_cpu.store(FSPG_ADDR_PTR_HIGH, 8'h03);
    i_cpu.store(FSPG_ADDR_PTR_LOW, 8'hFE);
    ev(5'b00001);
    chk(ptr_low, 8'hFF);
    ev(5'b00001);
    chk(ptr_low, 8'hFF);
    chk(ptr_high, 8'h03);
  endtask

  // Reset in mid-run with self programming active and a flag set
  task automatic t_reset();
    i_cpu.store(FSPG_ADDR_COMMAND, 8'h05);
    unlock(8'h01);
    ev(5'b00100);
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h02);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h00);
    rchk(FSPG_ADDR_MODE_CONTROL, 8'h6C);
    chk(8'(cmd_out.self_prog), 8'h00);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    rchk(FSPG_ADDR_ERROR_STATUS, 8'h00);
    t_unlock();
    t_broken();
    t_events();
    t_codes();
    t_pointer();
    t_reset();
    summarize();
  end
endmodule

`default_nettype wire
